// File: fsp_pkg.sv
// Purpose: Shared constants and types for the flash status polling host
// Assumes: 125 MHz system clock
// Notes: Device status layout and command codes of the polled flash

package fsp_pkg;

  // ----------------------------------------------------------------
  // Status byte fields
  // ----------------------------------------------------------------
  localparam int unsigned POLL_BIT = 7;
  localparam int unsigned ACT_TOG_BIT = 6;
  localparam int unsigned FAIL_BIT = 5;
  localparam int unsigned ERASE_WIN_BIT = 3;
  localparam int unsigned ERASE_TOG_BIT = 2;
  localparam int unsigned ABORT_BIT = 1;

  // ----------------------------------------------------------------
  // Command cycles
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_READ_RESET = 8'hf0;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'h2aa;

  // ----------------------------------------------------------------
  // Own register map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_LAST = 4'h4;
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_TOGGLE = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Bus timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned STROBE_NS = 70;
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_NS = 30;
  localparam int unsigned RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    RES_NONE,
    RES_DONE,
    RES_FAIL,
    RES_ABORT
  } fsp_result_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
    logic [7:0] dq_out;
    logic [11:0] addr;
  } fsp_flash_t;

endpackage

// File: fsp_host.sv
// Purpose: Host that polls a NOR flash status byte and recovers it after errors
// Assumes: Flash pins sampled synchronously; 12-bit low address is enough for polling
// Notes: One poll job per start; result and last status byte held in registers
`timescale 1ns/1ps

module fsp_host (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output fsp_pkg::fsp_flash_t flash,
  input wire logic [7:0] flash_dq_in
);

  typedef enum {
    S_IDLE,
    S_RD_A,
    S_RD_A_GAP,
    S_RD_B,
    S_EVAL,
    S_WR,
    S_WR_GAP,
    S_DONE
  } fsp_state_t;

  fsp_state_t state;
  fsp_state_t next_state;
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [11:0] poll_addr;
  logic [11:0] next_poll_addr;
  logic [7:0] poll_data;
  logic [7:0] next_poll_data;
  logic [7:0] first_rd;
  logic [7:0] next_first_rd;
  logic [7:0] last_rd;
  logic [7:0] next_last_rd;
  logic busy;
  logic next_busy;
  fsp_pkg::fsp_result_t result;
  fsp_pkg::fsp_result_t next_result;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [1:0] wr_idx;
  logic [1:0] next_wr_idx;
  logic [1:0] wr_total;
  logic [1:0] next_wr_total;
  logic [1:0] fail_kind;
  logic [1:0] next_fail_kind;
  fsp_pkg::fsp_flash_t next_flash;
  logic [31:0] next_reg_rdata;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] wr_data(input logic [1:0] idx, input logic [1:0] total);
    if (total == 2'd1) begin
      wr_data = fsp_pkg::CMD_READ_RESET;
    end else begin
      unique case (idx)
        2'd0: wr_data = fsp_pkg::CMD_UNLOCK1;
        2'd1: wr_data = fsp_pkg::CMD_UNLOCK2;
        default: wr_data = fsp_pkg::CMD_READ_RESET;
      endcase
    end
  endfunction

  function automatic logic [11:0] wr_addr(input logic [1:0] idx);
    wr_addr = (idx == 2'd1) ? fsp_pkg::ADDR_UNLOCK2 : fsp_pkg::ADDR_UNLOCK1;
  endfunction

  // ----------------------------------------------------------------
  // Poll sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_ctrl = ctrl;
    next_poll_addr = poll_addr;
    next_poll_data = poll_data;
    next_first_rd = first_rd;
    next_last_rd = last_rd;
    next_busy = busy;
    next_result = result;
    next_cnt = cnt;
    next_wr_idx = wr_idx;
    next_wr_total = wr_total;
    next_fail_kind = fail_kind;
    next_flash = flash;
    next_reg_rdata = 32'h0000_0000;
    if (reg_write && !busy) begin
      unique case (reg_addr)
        fsp_pkg::REG_CTRL: next_ctrl = reg_wdata;
        fsp_pkg::REG_ADDR: next_poll_addr = reg_wdata[11:0];
        fsp_pkg::REG_DATA: next_poll_data = reg_wdata[7:0];
        default: ;
      endcase
    end
    if (reg_read) begin
      unique case (reg_addr)
        fsp_pkg::REG_CTRL: next_reg_rdata = ctrl;
        fsp_pkg::REG_ADDR: next_reg_rdata = {20'h00000, poll_addr};
        fsp_pkg::REG_DATA: next_reg_rdata = {24'h000000, poll_data};
        fsp_pkg::REG_STATUS: next_reg_rdata = {28'h0000000, result, 1'b0, busy};
        fsp_pkg::REG_LAST: next_reg_rdata = {24'h000000, last_rd};
        default: next_reg_rdata = 32'h0000_0000;
      endcase
    end
    unique case (state)
      S_IDLE: begin
        if (ctrl[fsp_pkg::CTRL_START]) begin
          next_ctrl[fsp_pkg::CTRL_START] = 1'b0;
          next_busy = 1'b1;
          next_result = fsp_pkg::RES_NONE;
          next_state = S_RD_A;
          next_cnt = 8'h00;
        end
      end
      S_RD_A, S_RD_B: begin
        next_flash.addr = poll_addr;
        next_flash.ce_n = 1'b0;
        next_flash.oe_n = 1'b0;
        next_flash.we_n = 1'b1;
        next_flash.dq_oe = 1'b0;
        next_cnt = cnt + 8'h01;
        if (cnt == 8'(fsp_pkg::STROBE_CYC)) begin
          next_flash.ce_n = 1'b1;
          next_flash.oe_n = 1'b1;
          next_cnt = 8'h00;
          next_last_rd = flash_dq_in;
          if (state == S_RD_A) begin
            next_first_rd = flash_dq_in;
            next_state = S_RD_A_GAP;
          end else begin
            next_state = S_EVAL;
          end
        end
      end
      S_RD_A_GAP: begin
        next_cnt = cnt + 8'h01;
        if (cnt == 8'(fsp_pkg::RECOVER_CYC)) begin
          next_cnt = 8'h00;
          next_state = S_RD_B;
        end
      end
      S_EVAL: begin
        next_state = S_RD_A;
        if (ctrl[fsp_pkg::CTRL_TOGGLE]) begin
          if (first_rd[fsp_pkg::ACT_TOG_BIT] == last_rd[fsp_pkg::ACT_TOG_BIT]) begin
            next_result = fsp_pkg::RES_DONE;
            next_state = S_DONE;
          end
        end else if (last_rd[fsp_pkg::POLL_BIT] == poll_data[fsp_pkg::POLL_BIT]) begin
          next_result = fsp_pkg::RES_DONE;
          next_state = S_DONE;
        end
        if (next_state != S_DONE) begin
          if (last_rd[fsp_pkg::FAIL_BIT]) begin
            next_fail_kind = 2'd1;
          end else if (last_rd[fsp_pkg::ABORT_BIT]) begin
            next_fail_kind = 2'd3;
          end else begin
            next_fail_kind = 2'd0;
          end
          if (last_rd[fsp_pkg::FAIL_BIT] || last_rd[fsp_pkg::ABORT_BIT]) begin
            next_wr_total = last_rd[fsp_pkg::FAIL_BIT] ? 2'd1 : 2'd3;
            next_result = last_rd[fsp_pkg::FAIL_BIT] ? fsp_pkg::RES_FAIL : fsp_pkg::RES_ABORT;
            next_wr_idx = 2'd0;
            next_state = S_WR;
          end
        end
      end
      S_WR: begin
        next_flash.addr = wr_addr(wr_idx);
        next_flash.dq_out = wr_data(wr_idx, wr_total);
        next_flash.dq_oe = 1'b1;
        next_flash.ce_n = 1'b0;
        next_flash.we_n = 1'b0;
        next_flash.oe_n = 1'b1;
        next_cnt = cnt + 8'h01;
        if (cnt == 8'(fsp_pkg::STROBE_CYC)) begin
          next_flash.we_n = 1'b1;
          next_flash.ce_n = 1'b1;
          next_cnt = 8'h00;
          next_state = S_WR_GAP;
        end
      end
      S_WR_GAP: begin
        next_flash.dq_oe = 1'b0;
        next_cnt = cnt + 8'h01;
        if (cnt == 8'(fsp_pkg::RECOVER_CYC)) begin
          next_cnt = 8'h00;
          next_wr_idx = wr_idx + 2'd1;
          next_state = (wr_idx + 2'd1 == wr_total) ? S_DONE : S_WR;
        end
      end
      S_DONE: begin
        next_busy = 1'b0;
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      ctrl <= fsp_pkg::CTRL_RESET;
      poll_addr <= 12'h000;
      poll_data <= 8'h00;
      first_rd <= 8'h00;
      last_rd <= 8'h00;
      busy <= 1'b0;
      result <= fsp_pkg::RES_NONE;
      cnt <= 8'h00;
      wr_idx <= 2'd0;
      wr_total <= 2'd0;
      fail_kind <= 2'd0;
      flash <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0, dq_out: 8'h00, addr: 12'h000};
      reg_rdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      poll_addr <= next_poll_addr;
      poll_data <= next_poll_data;
      first_rd <= next_first_rd;
      last_rd <= next_last_rd;
      busy <= next_busy;
      result <= next_result;
      cnt <= next_cnt;
      wr_idx <= next_wr_idx;
      wr_total <= next_wr_total;
      fail_kind <= next_fail_kind;
      flash <= next_flash;
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule

// File: fsp_host_asserts.sv
// Purpose: Port checks for the status polling host
// Assumes: One clock domain
// Notes: Bound to every fsp_host instance
`timescale 1ns/1ps
module fsp_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire fsp_pkg::fsp_flash_t flash,
  input wire logic [7:0] flash_dq_in
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ----
  // Checks
  // ----
  property p_rdata_idle; !$past(reg_read) |-> reg_rdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its slot");
  property p_no_clash; !(!flash.oe_n && !flash.we_n); endproperty
  a_no_clash: assert property (p_no_clash) else $error("read and write strobes together");
  property p_ce_idle; flash.ce_n |-> flash.oe_n && flash.we_n; endproperty
  a_ce_idle: assert property (p_ce_idle) else $error("strobe without chip enable");
  property p_no_drive; !flash.oe_n |-> !flash.dq_oe; endproperty
  a_no_drive: assert property (p_no_drive) else $error("host drives bus during read");
  property p_read_len; $fell(flash.oe_n) |-> (!flash.oe_n)[*8] ##1 !flash.oe_n ##1 flash.oe_n; endproperty
  a_read_len: assert property (p_read_len) else $error("read strobe length wrong");
  property p_read_gap; $rose(flash.oe_n) |-> flash.oe_n[*2]; endproperty
  a_read_gap: assert property (p_read_gap) else $error("reads not separated");
  property p_addr_hold; !flash.oe_n && !$fell(flash.oe_n) |-> $stable(flash.addr); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in read");
  property p_start; reg_write && reg_addr == fsp_pkg::REG_CTRL && reg_wdata[0] |-> ##[1:4] $fell(flash.oe_n); endproperty
  a_start: assert property (p_start) else $error("poll did not start");
  property p_codes; $fell(flash.we_n) |-> flash.dq_oe && flash.dq_out inside {8'haa, 8'h55, 8'hf0}; endproperty
  a_codes: assert property (p_codes) else $error("unexpected command byte");
  property p_unlock; !flash.we_n && flash.dq_out == fsp_pkg::CMD_UNLOCK1 |-> flash.addr == fsp_pkg::ADDR_UNLOCK1; endproperty
  a_unlock: assert property (p_unlock) else $error("first unlock address wrong");
  property p_seq; $fell(flash.we_n) && flash.dq_out == 8'haa |-> ##[1:60] ($fell(flash.we_n) && flash.dq_out == 8'h55); endproperty
  a_seq: assert property (p_seq) else $error("second unlock cycle missing");
endmodule
bind fsp_host fsp_chk fsp_chk_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .flash(flash), .flash_dq_in(flash_dq_in));

// File: fsp_dev.sv
// Purpose: Behavioural flash answering status reads
// Assumes: Pins sampled on the host clock
// Notes: Released bus shows the inverse of its last value
`timescale 1ns/1ps
module fsp_dev (
  input wire logic clock,
  input wire fsp_pkg::fsp_flash_t flash,
  input wire logic arm,
  input wire logic [1:0] op,
  input wire logic [7:0] arr,
  output logic [7:0] dq,
  output logic rec_ok,
  output logic [11:0] seen
);
  logic busy = 0, err = 0, abt = 0, tog = 0, pr_oe = 1, pr_we = 1;
  logic [1:0] seq = 0;
  logic [7:0] cnt = 0, last = 0, wd = 0, stat;
  assign stat = {op == 2'h1 ? 1'b0 : ~arr[7], tog, err, 1'b0, op == 2'h1, op == 2'h1 & tog, abt, 1'b0};
  assign dq = (!flash.ce_n && !flash.oe_n) ? (busy ? stat : arr) : ~last;
  always @(posedge clock) begin
    pr_oe <= flash.oe_n;
    pr_we <= flash.we_n;
    if (!flash.oe_n) begin
      last <= dq;
      seen <= flash.addr;
    end
    if (!flash.we_n) wd <= flash.dq_out;
    if (arm) begin
      {busy, err, abt, tog, rec_ok} <= 5'h10;
      cnt <= 8'h3;
      seq <= 2'h0;
    end else if (busy && flash.oe_n && !pr_oe) begin
      tog <= ~tog;
      if (cnt != 0) cnt <= cnt - 8'h1;
      else if (op == 2'h2) err <= 1;
      else if (op == 2'h3) abt <= 1;
      else busy <= 0;
    end else if (busy && flash.we_n && !pr_we) begin
      seq <= wd == 8'haa ? 2'h1 : (seq == 2'h1 && wd == 8'h55 ? 2'h2 : 2'h0);
      if ((err && wd == 8'hf0) || (abt && seq == 2'h2 && wd == 8'hf0)) {busy, err, abt, rec_ok} <= 4'h1;
    end
  end
endmodule

// File: tb_top.sv
// Purpose: Self-checking bench for fsp_host
// Assumes: Device model answers four busy reads
// Notes: Poll and toggle methods, failure and abort recovery
`timescale 1ns/1ps
module tb_top;
  logic clock = 0, rst = 1, reg_write = 0, reg_read = 0, arm = 0, rec_ok;
  logic [3:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, rd;
  fsp_pkg::fsp_flash_t flash;
  logic [7:0] dq, arr = 0;
  logic [1:0] op = 0;
  logic [11:0] seen;
  int num_errors = 0, checks_done = 0, cycles = 0;
  initial forever #4 clock = ~clock;
  fsp_host fsp_host_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .flash(flash), .flash_dq_in(dq));
  fsp_dev fsp_dev_inst (.clock(clock), .flash(flash), .arm(arm), .op(op), .arr(arr), .dq(dq),
    .rec_ok(rec_ok), .seen(seen));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1;
    @(posedge clock);
    reg_write <= 0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1;
    @(posedge clock);
    reg_read <= 0;
    #1 rd = reg_rdata;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic job(input logic [1:0] o, input logic [7:0] a, input logic [31:0] ctl, input logic [1:0] res);
    int n;
    @(posedge clock);
    op <= o;
    arr <= a;
    arm <= 1;
    @(posedge clock);
    arm <= 0;
    wr(fsp_pkg::REG_ADDR, 32'h123);
    wr(fsp_pkg::REG_DATA, {24'h0, a});
    wr(fsp_pkg::REG_CTRL, ctl);
    n = 0;
    do begin
      rdr(fsp_pkg::REG_STATUS);
      n++;
    end while (rd[0] !== 1'b0 && n < 300);
    chk({29'h0, rd[3:2], rd[0]}, {29'h0, res, 1'b0});
    chk({20'h0, seen}, 32'h123);
  endtask
  task automatic t_regs;
    rdr(fsp_pkg::REG_STATUS);
    chk(rd, 32'h0);
    rdr(fsp_pkg::REG_CTRL);
    chk(rd, fsp_pkg::CTRL_RESET);
    rdr(4'hf);
    chk(rd, 32'h0);
  endtask
  task automatic t_program;
    job(2'h0, 8'h80, 32'h1, 2'h1);
    rdr(fsp_pkg::REG_LAST);
    chk(rd, 32'h80);
  endtask
  task automatic t_erase;
    job(2'h1, 8'h5a, 32'h3, 2'h1);
    rdr(fsp_pkg::REG_LAST);
    chk(rd, 32'h5a);
  endtask
  task automatic t_fail;
    job(2'h2, 8'h00, 32'h1, 2'h2);
    chk({31'h0, rec_ok}, 32'h1);
  endtask
  task automatic t_abort;
    job(2'h3, 8'h00, 32'h1, 2'h3);
    chk({31'h0, rec_ok}, 32'h1);
  endtask
  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Jobs take under two hundred cycles each
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 0;
    t_regs();
    t_program();
    t_erase();
    t_fail();
    t_abort();
    report_and_stop();
  end
endmodule
